// ===== design/frdc_pkg.sv
// shared constants and types for the read data command engine
package frdc_pkg;
  // clock and timer granularity
  localparam int unsigned CLK_HZ = 200_000_000;
  localparam int unsigned TICK_US = 1000;
  localparam int unsigned TICK_CYC = CLK_HZ / 1_000_000 * TICK_US;
  // command opcodes, bits 4..0 of the first byte
  localparam logic [4:0] OP_READ_DATA = 5'h06;
  localparam logic [4:0] OP_READ_DEL = 5'h0C;
  // first command byte fields
  localparam int unsigned B0_MT = 7;
  localparam int unsigned B0_SK = 5;
  // second command byte fields
  localparam int unsigned B1_HDS = 2;
  // byte indices within the command
  localparam logic [3:0] CI_SEL = 4'h1;
  localparam logic [3:0] CI_CYL = 4'h2;
  localparam logic [3:0] CI_HEAD = 4'h3;
  localparam logic [3:0] CI_SEC = 4'h4;
  localparam logic [3:0] CI_SIZE = 4'h5;
  localparam logic [3:0] CI_EOT = 4'h6;
  localparam logic [3:0] CI_DTL = 4'h8;
  localparam logic [3:0] CMD_LAST = 4'h8;
  // result phase lengths
  localparam logic [2:0] RES_LAST = 3'h6;
  localparam logic [2:0] RES_LAST_INV = 3'h0;
  // interrupt codes
  localparam logic [1:0] IC_NORMAL = 2'h0;
  localparam logic [1:0] IC_ABNORMAL = 2'h1;
  localparam logic [1:0] IC_INVALID = 2'h2;
  // sector geometry
  localparam logic [7:0] SEC_FIRST = 8'h01;
  localparam logic [14:0] SHORT_SECTOR = 15'h0080;
  localparam logic [1:0] IDX_LIMIT = 2'h2;
  // engine states
  typedef enum logic [2:0] {
    FRDC_IDLE = 3'b000,
    FRDC_CMD = 3'b001,
    FRDC_SEEK = 3'b010,
    FRDC_LOAD = 3'b011,
    FRDC_SETTLE = 3'b100,
    FRDC_SCAN = 3'b101,
    FRDC_DATA = 3'b110,
    FRDC_RESULT = 3'b111
  } frdc_state_e;
endpackage

// ===== design/frdc_sync3.sv
// three-flop synchroniser with agreement filter for pin inputs
module frdc_sync3 #(
  parameter int unsigned WIDTH = 2
) (
  input wire logic clk_in,
  input wire logic sys_rst_in,
  input wire logic [WIDTH-1:0] pin_in,
  input wire logic [WIDTH-1:0] rst_val_in,
  output logic [WIDTH-1:0] level_out
);
  logic [WIDTH-1:0] s1_q;
  logic [WIDTH-1:0] s2_q;
  logic [WIDTH-1:0] s3_q;
  logic [WIDTH-1:0] lvl_q;

  // per bit: only stage two reads stage one; output moves on agreement
  for (genvar i = 0; i < WIDTH; i++) begin : g_bit
    always_ff @(posedge clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
        s1_q[i] <= 1'b0;
        s2_q[i] <= 1'b0;
        s3_q[i] <= 1'b0;
        lvl_q[i] <= 1'b0;
      end else begin
        s1_q[i] <= pin_in[i] ^ rst_val_in[i];
        s2_q[i] <= s1_q[i];
        s3_q[i] <= s2_q[i];
        if (s2_q[i] == s3_q[i]) begin
          lvl_q[i] <= s3_q[i];
        end
      end
    end
  end

  // idle level is applied outside the flops, so reset stays constant
  assign level_out = lvl_q ^ rst_val_in;
endmodule

// ===== design/frdc_timer.sv
// countdown of whole ticks, used for head settle and head unload
module frdc_timer #(
  parameter int unsigned TICK = 200000
) (
  input wire logic clk_in,
  input wire logic sys_rst_in,
  input wire logic start_in,
  input wire logic [7:0] units_in,
  output logic expired_out
);
  localparam logic [17:0] TICK_LAST = 18'(TICK - 1);
  logic [17:0] sub_q;
  logic [7:0] units_q;
  logic expired_q;

  // prescaler restarts on start so the first unit is full length
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      sub_q <= 18'h00000;
      units_q <= 8'h00;
      expired_q <= 1'b1;
    end else if (start_in) begin
      sub_q <= TICK_LAST;
      units_q <= units_in;
      expired_q <= (units_in == 8'h00);
    end else if (!expired_q) begin
      if (sub_q != 18'h00000) begin
        sub_q <= sub_q - 18'h00001;
      end else begin
        sub_q <= TICK_LAST;
        units_q <= units_q - 8'h01;
        expired_q <= (units_q == 8'h01);
      end
    end
  end

  assign expired_out = expired_q;
endmodule

// ===== design/frdc_engine.sv
// read data command engine: command bytes, search, transfer, results
//
// Summary of operation
// - read data and read deleted share parameters and results; opcode is bits 4..0
// - with implied seek enabled, seek first, drive busy bit held meanwhile
// - failed seek reported in status zero, cylinder holds failing position
// - load head, settle if unloaded, match sector ID, move data to FIFO
// - after each sector, step sector number and read the next one
// - transfer end or FIFO overrun stops data; finish sector, check CRC
// - size code selects 128 shifted left by the code, up to 16 Kbytes
// - size zero with short length below 128 sends only that many bytes
// - both-sides flag reads side 0 then side 1 of one cylinder
// - head stays loaded for unload interval; new command skips settling
// - two index pulses with no ID field seen between them: code 01, no-data flag, stop
// - ID or data CRC error: code 01, data error, ID case field CRC
// - deleted-pass clear: deleted mark read, control mark set, no advance
// - deleted-pass set: deleted mark skipped with control mark set
// - sector address advances automatically unless skip handling forbids
// - at last sector, sector returns 01; side 0 with both-sides flips head
module frdc_engine
  import frdc_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = TICK_CYC
) (
  input wire logic clk_in,
  input wire logic sys_rst_in,
  // host command and result bytes
  input wire logic [7:0] cmd_byte_in,
  input wire logic cmd_wr_in,
  input wire logic res_rd_in,
  output logic [7:0] res_byte_out,
  output logic res_valid_out,
  output logic cmd_busy_out,
  // configuration
  input wire logic implied_seek_en_in,
  input wire logic [7:0] settle_units_in,
  input wire logic [7:0] unload_units_in,
  // fifo toward the host
  input wire logic fifo_full_in,
  output logic [7:0] fifo_data_out,
  output logic fifo_wr_out,
  // seek logic
  input wire logic seek_done_in,
  input wire logic seek_fail_in,
  input wire logic [7:0] seek_fail_cyl_in,
  output logic seek_req_out,
  output logic [7:0] seek_cyl_out,
  output logic [3:0] drive_busy_out,
  // drive pins and data separator
  input wire logic hole_pulse_n_in,
  input wire logic transfer_end_signal_in,
  input wire logic id_found_in,
  input wire logic id_crc_ok_in,
  input wire logic [7:0] id_cyl_in,
  input wire logic [7:0] id_head_in,
  input wire logic [7:0] id_sec_in,
  input wire logic [7:0] id_size_in,
  input wire logic mark_found_in,
  input wire logic mark_deleted_in,
  input wire logic [7:0] rd_byte_in,
  input wire logic rd_byte_valid_in,
  input wire logic field_end_in,
  input wire logic field_crc_ok_in,
  output logic head_load_out,
  output logic head_sel_out,
  output logic [1:0] drive_sel_out
);
  frdc_state_e state_q;
  logic [3:0] cmd_idx_q;
  logic [2:0] res_idx_q, res_last_q;
  logic both_sides_flag_q, deleted_pass_flag_q, want_del_q, hds_q;
  logic [1:0] ds_q, interrupt_code_q, idx_cnt_q, pins;
  logic [7:0] cyl_q, head_q, sec_q, size_q, last_sector_number_q;
  logic [7:0] short_length_q, st0, st1, st2;
  logic equip_q, no_data_flag_q, data_error_flag_q, field_crc_flag_q;
  logic control_mark_flag_q, mark_seen_q, skip_q, stop_q, head_loaded_q;
  logic [14:0] byte_cnt_q, xfer_len, sector_len;
  logic idx_prev_q, idx_rise, stop_now, mark_mismatch, at_last, end_cyl;
  logic settle_start, settle_done, unload_start, unload_done, seek_go;

  // index pulse idles high (active low); transfer end idles low
  frdc_sync3 #(.WIDTH(2)) u_sync (
    .clk_in(clk_in),
    .sys_rst_in(sys_rst_in),
    .pin_in({transfer_end_signal_in, hole_pulse_n_in}),
    .rst_val_in(2'b01),
    .level_out(pins)
  );

  frdc_timer #(.TICK(TICK_CYCLES)) u_settle (
    .clk_in(clk_in),
    .sys_rst_in(sys_rst_in),
    .start_in(settle_start),
    .units_in(settle_units_in),
    .expired_out(settle_done)
  );

  frdc_timer #(.TICK(TICK_CYCLES)) u_unload (
    .clk_in(clk_in),
    .sys_rst_in(sys_rst_in),
    .start_in(unload_start),
    .units_in(unload_units_in),
    .expired_out(unload_done)
  );

  // rising edge of the active index level
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      idx_prev_q <= 1'b0;
    end else begin
      idx_prev_q <= !pins[0];
    end
  end
  assign idx_rise = !pins[0] && !idx_prev_q;

  // bytes per sector and bytes actually handed to the host
  assign sector_len = SHORT_SECTOR << size_q[2:0];
  always_comb begin
    if (size_q[2:0] == 3'h0 && short_length_q < SHORT_SECTOR[7:0]) begin
      xfer_len = {7'h00, short_length_q};
    end else begin
      xfer_len = sector_len;
    end
  end

  assign stop_now = pins[1] || (fifo_wr_out && fifo_full_in);
  assign mark_mismatch = mark_deleted_in != want_del_q;
  assign at_last = sec_q == last_sector_number_q;
  // with both sides, only side 1 closes the cylinder
  assign end_cyl = at_last && !(both_sides_flag_q && !head_q[0]);
  assign settle_start = state_q == FRDC_LOAD && !head_loaded_q;
  assign unload_start = state_q == FRDC_DATA && field_end_in;
  assign seek_go = state_q == FRDC_CMD && cmd_wr_in &&
                   cmd_idx_q == CMD_LAST && implied_seek_en_in;

  // status bytes presented in the result phase
  assign st0 = {interrupt_code_q, 1'b0, equip_q, 1'b0, hds_q, ds_q};
  assign st1 = {2'b00, data_error_flag_q, 2'b00, no_data_flag_q, 2'b00};
  assign st2 = {1'b0, control_mark_flag_q, field_crc_flag_q, 5'h00};

  // main sequence
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      state_q <= FRDC_IDLE;
      cmd_idx_q <= 4'h0;
      res_idx_q <= 3'h0;
      res_last_q <= RES_LAST;
    end else begin
      unique case (state_q)
        FRDC_IDLE: begin
          res_idx_q <= 3'h0;
          cmd_idx_q <= 4'h1;
          if (cmd_wr_in) begin
            // only the low five bits tell the commands apart
            if (cmd_byte_in[4:0] == OP_READ_DATA ||
                cmd_byte_in[4:0] == OP_READ_DEL) begin
              state_q <= FRDC_CMD;
            end else begin
              res_last_q <= RES_LAST_INV;
              state_q <= FRDC_RESULT;
            end
          end
        end
        FRDC_CMD: begin
          if (cmd_wr_in) begin
            cmd_idx_q <= cmd_idx_q + 4'h1;
            if (cmd_idx_q == CMD_LAST) begin
              res_last_q <= RES_LAST;
              state_q <= implied_seek_en_in ? FRDC_SEEK : FRDC_LOAD;
            end
          end
        end
        FRDC_SEEK: begin
          if (seek_fail_in) begin
            state_q <= FRDC_RESULT;
          end else if (seek_done_in) begin
            state_q <= FRDC_LOAD;
          end
        end
        FRDC_LOAD: begin
          // a head still loaded from the last command needs no settle
          state_q <= head_loaded_q ? FRDC_SCAN : FRDC_SETTLE;
        end
        FRDC_SETTLE: begin
          if (settle_done) begin
            state_q <= FRDC_SCAN;
          end
        end
        FRDC_SCAN: begin
          if (id_found_in && !id_crc_ok_in) begin
            state_q <= FRDC_RESULT;
          end else if (id_found_in && id_cyl_in == cyl_q &&
                       id_head_in == head_q && id_sec_in == sec_q &&
                       id_size_in == size_q) begin
            state_q <= FRDC_DATA;
          end else if (idx_rise && idx_cnt_q == IDX_LIMIT - 2'h1) begin
            state_q <= FRDC_RESULT;
          end
        end
        FRDC_DATA: begin
          if (field_end_in) begin
            if (!field_crc_ok_in || stop_q || stop_now || end_cyl ||
                (control_mark_flag_q && !deleted_pass_flag_q)) begin
              state_q <= FRDC_RESULT;
            end else begin
              state_q <= FRDC_SCAN;
            end
          end
        end
        FRDC_RESULT: begin
          if (res_rd_in && res_valid_out) begin
            res_idx_q <= res_idx_q + 3'h1;
            if (res_idx_q == res_last_q) begin
              state_q <= FRDC_IDLE;
            end
          end
        end
      endcase
    end
  end

  // parameter capture and sector address advance
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      both_sides_flag_q <= 1'b0;
      deleted_pass_flag_q <= 1'b0;
      want_del_q <= 1'b0;
      hds_q <= 1'b0;
      ds_q <= 2'h0;
      cyl_q <= 8'h00;
      head_q <= 8'h00;
      sec_q <= 8'h00;
      size_q <= 8'h00;
      last_sector_number_q <= 8'h00;
      short_length_q <= 8'h00;
    end else if (state_q == FRDC_IDLE && cmd_wr_in) begin
      both_sides_flag_q <= cmd_byte_in[B0_MT];
      deleted_pass_flag_q <= cmd_byte_in[B0_SK];
      want_del_q <= cmd_byte_in[4:0] == OP_READ_DEL;
      hds_q <= 1'b0;
      ds_q <= 2'h0;
    end else if (state_q == FRDC_CMD && cmd_wr_in) begin
      unique case (cmd_idx_q)
        CI_SEL: {hds_q, ds_q} <= cmd_byte_in[B1_HDS:0];
        CI_CYL: cyl_q <= cmd_byte_in;
        CI_HEAD: head_q <= cmd_byte_in;
        CI_SEC: sec_q <= cmd_byte_in;
        CI_SIZE: size_q <= cmd_byte_in;
        CI_EOT: last_sector_number_q <= cmd_byte_in;
        CI_DTL: short_length_q <= cmd_byte_in;
        default: ;
      endcase
    end else if (state_q == FRDC_SEEK && seek_fail_in) begin
      cyl_q <= seek_fail_cyl_in;
    end else if (state_q == FRDC_DATA && field_end_in && field_crc_ok_in &&
                 !(control_mark_flag_q && !deleted_pass_flag_q)) begin
      if (at_last) begin
        sec_q <= SEC_FIRST;
        if (both_sides_flag_q) begin
          head_q[0] <= !head_q[0];
          hds_q <= !hds_q;
        end
        if (!both_sides_flag_q || head_q[0]) begin
          cyl_q <= cyl_q + 8'h01;
        end
      end else begin
        sec_q <= sec_q + 8'h01;
      end
    end
  end

  // error and status flags, cleared when a command starts
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      interrupt_code_q <= IC_NORMAL;
      equip_q <= 1'b0;
      no_data_flag_q <= 1'b0;
      data_error_flag_q <= 1'b0;
      field_crc_flag_q <= 1'b0;
      control_mark_flag_q <= 1'b0;
    end else if (state_q == FRDC_IDLE && cmd_wr_in) begin
      interrupt_code_q <= IC_NORMAL;
      equip_q <= 1'b0;
      no_data_flag_q <= 1'b0;
      data_error_flag_q <= 1'b0;
      field_crc_flag_q <= 1'b0;
      control_mark_flag_q <= 1'b0;
      if (cmd_byte_in[4:0] != OP_READ_DATA &&
          cmd_byte_in[4:0] != OP_READ_DEL) begin
        interrupt_code_q <= IC_INVALID;
      end
    end else if (state_q == FRDC_SEEK && seek_fail_in) begin
      interrupt_code_q <= IC_ABNORMAL;
      equip_q <= 1'b1;
    end else if (state_q == FRDC_SCAN) begin
      if (id_found_in && !id_crc_ok_in) begin
        interrupt_code_q <= IC_ABNORMAL;
        data_error_flag_q <= 1'b1;
        field_crc_flag_q <= 1'b1;
      end else if (!id_found_in && idx_rise &&
                   idx_cnt_q == IDX_LIMIT - 2'h1) begin
        interrupt_code_q <= IC_ABNORMAL;
        no_data_flag_q <= 1'b1;
      end
    end else if (state_q == FRDC_DATA) begin
      if (mark_found_in && !mark_seen_q && mark_mismatch) begin
        control_mark_flag_q <= 1'b1;
      end
      if (field_end_in && !field_crc_ok_in) begin
        interrupt_code_q <= IC_ABNORMAL;
        data_error_flag_q <= 1'b1;
      end
    end
  end

  // index counting and per-sector transfer tracking
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      idx_cnt_q <= 2'h0;
      mark_seen_q <= 1'b0;
      skip_q <= 1'b0;
      stop_q <= 1'b0;
      byte_cnt_q <= 15'h0000;
    end else if (state_q == FRDC_IDLE) begin
      idx_cnt_q <= 2'h0;
      stop_q <= 1'b0;
    end else if (state_q == FRDC_SCAN) begin
      mark_seen_q <= 1'b0;
      skip_q <= 1'b0;
      byte_cnt_q <= 15'h0000;
      if (id_found_in) begin
        idx_cnt_q <= 2'h0;
      end else if (idx_rise) begin
        idx_cnt_q <= idx_cnt_q + 2'h1;
      end
      stop_q <= stop_q || stop_now;
    end else if (state_q == FRDC_DATA) begin
      stop_q <= stop_q || stop_now;
      if (mark_found_in && !mark_seen_q) begin
        mark_seen_q <= 1'b1;
        skip_q <= mark_mismatch && deleted_pass_flag_q;
      end
      if (rd_byte_valid_in) begin
        byte_cnt_q <= byte_cnt_q + 15'h0001;
      end
    end
  end

  // data delivery; later bytes of the sector are read but dropped
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      fifo_data_out <= 8'h00;
      fifo_wr_out <= 1'b0;
    end else begin
      fifo_data_out <= rd_byte_in;
      fifo_wr_out <= state_q == FRDC_DATA && mark_seen_q && !skip_q &&
                     rd_byte_valid_in && !stop_q && !stop_now &&
                     byte_cnt_q < xfer_len;
    end
  end

  // head load state kept until the unload interval runs out
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      head_loaded_q <= 1'b0;
    end else if (settle_start) begin
      head_loaded_q <= 1'b1;
    end else if (state_q == FRDC_IDLE && unload_done) begin
      head_loaded_q <= 1'b0;
    end
  end

  // drive-facing outputs, all registered
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      seek_req_out <= 1'b0;
      seek_cyl_out <= 8'h00;
      drive_busy_out <= 4'h0;
      head_load_out <= 1'b0;
      head_sel_out <= 1'b0;
      drive_sel_out <= 2'h0;
    end else begin
      seek_req_out <= seek_go;
      seek_cyl_out <= cyl_q;
      for (int d = 0; d < 4; d++) begin
        drive_busy_out[d] <= (state_q == FRDC_SEEK || seek_go) &&
                             ds_q == 2'(d);
      end
      head_load_out <= head_loaded_q || settle_start;
      head_sel_out <= hds_q;
      drive_sel_out <= ds_q;
    end
  end

  // result byte presented from the index of the next read
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      res_byte_out <= 8'h00;
      res_valid_out <= 1'b0;
      cmd_busy_out <= 1'b0;
    end else begin
      res_valid_out <= state_q == FRDC_RESULT &&
                       !(res_rd_in && res_valid_out &&
                         res_idx_q == res_last_q);
      cmd_busy_out <= state_q != FRDC_IDLE ||
                      (cmd_wr_in && res_idx_q == 3'h0);
      unique case (res_idx_q + 3'(res_rd_in && res_valid_out))
        3'h0: res_byte_out <= st0;
        3'h1: res_byte_out <= st1;
        3'h2: res_byte_out <= st2;
        3'h3: res_byte_out <= cyl_q;
        3'h4: res_byte_out <= head_q;
        3'h5: res_byte_out <= sec_q;
        default: res_byte_out <= size_q;
      endcase
    end
  end
endmodule

// ===== verification/frdc_engine_sva.sv
// port assertions for the read data command engine
module frdc_chk (
  input wire logic clk_in,
  input wire logic sys_rst_in,
  input wire logic cmd_wr_in,
  input wire logic res_rd_in,
  input wire logic [7:0] res_byte_out,
  input wire logic res_valid_out,
  input wire logic cmd_busy_out,
  input wire logic fifo_full_in,
  input wire logic [7:0] fifo_data_out,
  input wire logic fifo_wr_out,
  input wire logic seek_req_out,
  input wire logic [3:0] drive_busy_out,
  input wire logic transfer_end_signal_in,
  input wire logic [7:0] rd_byte_in,
  input wire logic rd_byte_valid_in
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (sys_rst_in);
  // busy and idle
  property p_start; !cmd_busy_out && cmd_wr_in |=> cmd_busy_out; endproperty
  a_start: assert property (p_start) else $error("busy missing");
  property p_idle;
    !cmd_busy_out |-> !fifo_wr_out && !res_valid_out;
  endproperty
  a_idle: assert property (p_idle) else $error("output while idle");
  // fifo writes
  property p_wr; fifo_wr_out |-> $past(rd_byte_valid_in); endproperty
  a_wr: assert property (p_wr) else $error("stray fifo write");
  property p_dat;
    fifo_wr_out |-> fifo_data_out == $past(rd_byte_in);
  endproperty
  a_dat: assert property (p_dat) else $error("fifo byte wrong");
  // seek busy
  property p_seek; seek_req_out |=> drive_busy_out != 4'h0; endproperty
  a_seek: assert property (p_seek) else $error("drive not busy");
  // stopped delivery
  property p_ovr;
    fifo_wr_out && fifo_full_in |=> !fifo_wr_out [*8];
  endproperty
  a_ovr: assert property (p_ovr) else $error("write after overrun");
  property p_tc; transfer_end_signal_in [*8] |=> !fifo_wr_out; endproperty
  a_tc: assert property (p_tc) else $error("write after end");
  // result hold
  property p_hold;
    res_valid_out && !res_rd_in |=> res_valid_out && $stable(res_byte_out);
  endproperty
  a_hold: assert property (p_hold) else $error("result byte lost");
endmodule
bind frdc_engine frdc_chk i_frdc_chk (.*);

// ===== verification/frdc_disk.sv
// behavioural drive, data separator and seek logic facing the engine
module frdc_disk (
  input wire logic clk_in,
  input wire logic seek_req_out,
  input wire logic [7:0] seek_cyl_out,
  input wire logic head_load_out,
  output logic seek_done_in,
  output logic seek_fail_in,
  output logic [7:0] seek_fail_cyl_in,
  output logic hole_pulse_n_in,
  output logic id_found_in,
  output logic id_crc_ok_in,
  output logic [7:0] id_cyl_in,
  output logic [7:0] id_head_in,
  output logic [7:0] id_sec_in,
  output logic [7:0] id_size_in,
  output logic mark_found_in,
  output logic mark_deleted_in,
  output logic [7:0] rd_byte_in,
  output logic rd_byte_valid_in,
  output logic field_end_in,
  output logic field_crc_ok_in
);
  timeunit 1ns;
  timeprecision 1ps;
  int dly = 3; // gap cycles
  logic bad = 1'b0; // next seek fails
  initial begin
    {seek_done_in, seek_fail_in, id_found_in, mark_found_in} = '0;
    {rd_byte_valid_in, field_end_in, mark_deleted_in, id_crc_ok_in} = '0;
    {field_crc_ok_in, seek_fail_cyl_in, rd_byte_in, id_cyl_in} = '0;
    {id_head_in, id_sec_in, id_size_in} = '0;
    hole_pulse_n_in = 1'b1;
  end
  // seek answer; a failure skews the cylinder
  always @(posedge clk_in) if (seek_req_out === 1'b1) begin
    repeat (dly) @(posedge clk_in);
    seek_fail_cyl_in <= seek_cyl_out ^ 8'h5A;
    seek_done_in <= !bad;
    seek_fail_in <= bad;
    @(posedge clk_in) seek_done_in <= 1'b0;
    seek_fail_in <= 1'b0;
  end
  // one side 0 sector; idle data bus shows the inverse
  task sec(input logic [7:0] c, r, n, input int nb, input logic del = 1'b0,
           input logic idok = 1'b1, dok = 1'b1);
    wait (head_load_out === 1'b1);
    repeat (dly + 10) @(posedge clk_in);
    {id_cyl_in, id_head_in, id_sec_in, id_size_in} <= {c, 8'h00, r, n};
    id_crc_ok_in <= idok;
    id_found_in <= 1'b1;
    @(posedge clk_in) id_found_in <= 1'b0;
    if (!idok) return;
    @(posedge clk_in) mark_deleted_in <= del;
    mark_found_in <= 1'b1;
    @(posedge clk_in) mark_found_in <= 1'b0;
    for (int i = 0; i < nb; i++) begin
      @(posedge clk_in) rd_byte_in <= i[7:0];
      rd_byte_valid_in <= 1'b1;
      @(posedge clk_in) rd_byte_valid_in <= 1'b0;
      rd_byte_in <= ~i[7:0];
    end
    @(posedge clk_in) field_crc_ok_in <= dok;
    field_end_in <= 1'b1;
    @(posedge clk_in) field_end_in <= 1'b0;
  endtask
  // index hole, long enough for the pin filter
  task idx;
    @(posedge clk_in) hole_pulse_n_in <= 1'b0;
    repeat (6) @(posedge clk_in);
    hole_pulse_n_in <= 1'b1;
    repeat (20) @(posedge clk_in);
  endtask
endmodule

// ===== verification/tb_top.sv
// self-checking bench for the read data command engine
module tb_top
  import frdc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_in, sys_rst_in, cmd_wr_in, res_rd_in, res_valid_out;
  logic cmd_busy_out, implied_seek_en_in, fifo_full_in, fifo_wr_out;
  logic seek_done_in, seek_fail_in, seek_req_out, hole_pulse_n_in;
  logic transfer_end_signal_in, id_found_in, id_crc_ok_in, mark_found_in;
  logic mark_deleted_in, rd_byte_valid_in, field_end_in, field_crc_ok_in;
  logic head_load_out, head_sel_out;
  logic [1:0] drive_sel_out;
  logic [3:0] drive_busy_out;
  logic [7:0] cmd_byte_in, res_byte_out, settle_units_in, unload_units_in;
  logic [7:0] fifo_data_out, seek_fail_cyl_in, seek_cyl_out, id_cyl_in;
  logic [7:0] id_head_in, id_sec_in, id_size_in, rd_byte_in;
  logic [7:0] rb [7];
  logic [15:0] wr_cnt = 16'h0000;
  int err_count = 0;
  int num_checks = 0;
  frdc_engine #(.TICK_CYCLES(4)) i_frdc_engine (.*);
  frdc_disk dk (.*);
  initial begin
    clk_in = 1'b0;
    forever #2.5 clk_in = ~clk_in;
  end
  // fifo write count
  always @(posedge clk_in) if (fifo_wr_out === 1'b1) wr_cnt <= wr_cnt + 1'b1;
  task chk(input logic [15:0] seen, exp);
    num_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("mismatch at %0t seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  task summarize;
    $display("checks %0d errors %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // p = {op, C, R, N, LAST_SECTOR_NUMBER, SHORT_LENGTH}; drive 0, head 0, sent once idle
  task cmd(input logic [47:0] p);
    logic [71:0] v;
    v = {p[47:40], 8'h00, p[39:32], 8'h00, p[31:8], 8'h1B, p[7:0]};
    for (int k = 0; k < 200 && cmd_busy_out !== 1'b0; k++) @(negedge clk_in);
    wr_cnt = 16'h0000;
    for (int i = 0; i < 9; i++) begin
      @(posedge clk_in) cmd_byte_in <= v[71-8*i -: 8];
      cmd_wr_in <= 1'b1;
    end
    @(posedge clk_in) cmd_wr_in <= 1'b0;
  endtask
  // take n result bytes
  task res(input int n);
    for (int i = 0; i < n; i++) begin
      @(negedge clk_in);
      for (int k = 0; k < 9000 && res_valid_out !== 1'b1; k++)
        @(negedge clk_in);
      chk(res_valid_out, 1'b1);
      rb[i] = res_byte_out;
      @(posedge clk_in) res_rd_in <= 1'b1;
      @(posedge clk_in) res_rd_in <= 1'b0;
    end
  endtask
  // implied seek, two short sectors
  task t_multi;
    implied_seek_en_in <= 1'b1;
    cmd(48'h46_05_01_00_02_08);
    dk.sec(8'h05, 8'h01, 8'h00, 128);
    dk.sec(8'h05, 8'h02, 8'h00, 128);
    chk(head_load_out, 1'b1);
    res(7);
    implied_seek_en_in <= 1'b0;
    chk(wr_cnt, 16'h0010);
    chk(rb[0][7:6], IC_NORMAL);
    chk(rb[5], SEC_FIRST);
  endtask
  // sizes, short length ignored
  task t_sizes;
    for (int n = 0; n < 4; n++) begin
      cmd({24'h46_03_01, n[7:0], 16'h01_FF});
      dk.sec(8'h03, 8'h01, n[7:0], 128 << n);
      res(7);
      chk(wr_cnt, 16'h0080 << n);
    end
  endtask
  // slow failing seek
  task t_seekfail;
    implied_seek_en_in <= 1'b1;
    dk.bad = 1'b1;
    dk.dly = 40;
    cmd(48'h46_09_01_00_01_FF);
    res(7);
    chk(rb[0][7:6], IC_ABNORMAL);
    chk(rb[3], 8'h53);
    dk.bad = 1'b0;
    dk.dly = 3;
    implied_seek_en_in <= 1'b0;
  endtask
  // wrong id, two index holes
  task t_nodata;
    cmd(48'h46_02_03_00_03_FF);
    dk.sec(8'h02, 8'h07, 8'h00, 128);
    dk.idx();
    dk.idx();
    res(7);
    chk(rb[0][7:6], IC_ABNORMAL);
    chk(rb[1][2], 1'b1);
  endtask
  // bad id crc, then bad data crc
  task t_crc;
    for (int b = 0; b < 2; b++) begin
      cmd(48'h46_02_01_00_01_FF);
      dk.sec(8'h02, 8'h01, 8'h00, 128, 0, b[0], !b[0]);
      res(7);
      chk(rb[0][7:6], IC_ABNORMAL);
      chk(rb[1][5], 1'b1);
      chk(rb[2][5], !b[0]);
    end
  endtask
  // deleted mark: read and stop, or skip
  task t_deleted;
    cmd(48'h46_02_01_00_02_FF);
    dk.sec(8'h02, 8'h01, 8'h00, 128, 1);
    res(7);
    chk(wr_cnt, 16'h0080);
    chk(rb[2][6], 1'b1);
    chk(rb[5], 8'h01);
    cmd(48'h66_02_01_00_02_FF);
    dk.sec(8'h02, 8'h01, 8'h00, 128, 1);
    dk.sec(8'h02, 8'h02, 8'h00, 128);
    res(7);
    chk(wr_cnt, 16'h0080);
    chk(rb[2][6], 1'b1);
    chk(rb[5], SEC_FIRST);
  endtask
  // both sides, stopped on side 0 at the last sector
  task t_stop(input logic full);
    cmd(48'hC6_04_01_01_01_FF);
    fork
      dk.sec(8'h04, 8'h01, 8'h01, 256);
      begin
        wait (wr_cnt == 16'h000A);
        @(posedge clk_in) transfer_end_signal_in <= !full;
        fifo_full_in <= full;
      end
    join
    res(7);
    transfer_end_signal_in <= 1'b0;
    fifo_full_in <= 1'b0;
    chk(wr_cnt < 16'h0014, 1'b1);
    chk(rb[3], 8'h04);
    chk(rb[4], 8'h01);
    chk(rb[5], SEC_FIRST);
  endtask
  initial begin
    {cmd_wr_in, res_rd_in, implied_seek_en_in, fifo_full_in} = '0;
    transfer_end_signal_in = 1'b0;
    cmd_byte_in = 8'h00;
    settle_units_in = 8'h01;
    unload_units_in = 8'h03;
    sys_rst_in = 1'b1;
    repeat (10) @(posedge clk_in);
    sys_rst_in <= 1'b0;
    repeat (4) @(posedge clk_in);
    t_multi();
    t_sizes();
    t_seekfail();
    t_nodata();
    t_crc();
    t_deleted();
    t_stop(1'b0);
    t_stop(1'b1);
    cmd(48'h5F_01_01_00_01_FF);
    res(1);
    chk(rb[0], 8'h80);
    summarize();
  end
  // hang guard, about three times the expected run
  initial begin
    #100us;
    err_count++;
    summarize();
  end
endmodule
